// File: logic/video_irq_defines.vh
`ifndef VIDEO_IRQ_DEFINES_VH
`define VIDEO_IRQ_DEFINES_VH

// =====================================================================
// Register offsets
`define OFS_USER_SUBMAP   8'h0E
`define OFS_IRQ_CONFIG    8'h40
`define OFS_IRQ_MASK1     8'h44
`define OFS_RAW_STATUS2   8'h45
`define OFS_IRQ_STATUS2   8'h46
`define OFS_IRQ_CLEAR2    8'h47
`define OFS_IRQ_MASK2     8'h48

// =====================================================================
// Field positions and writable bit sets
`define SUBMAP_SEL_LSB    0
`define SUBMAP_SEL_IRQ    2'h1
`define CFG_DRIVE_LSB     0
`define CFG_MANUAL_BIT    2
`define CFG_WR_BITS       8'hF7
`define MASK1_WR_BITS     8'h63
`define MASK2_WR_BITS     8'hB1
`define BIT_CAPTION       0
`define BIT_FIELD         4
`define BIT_RANGE         5
`define BIT_MANUAL        7

// =====================================================================
// Drive select codes
`define DRIVE_OPEN_DRAIN  2'h0
`define DRIVE_ACTIVE_LOW  2'h1
`define DRIVE_ACTIVE_HIGH 2'h2

// =====================================================================
// Reset values
`define RST_BYTE          8'h00
`define SERIAL_ADDR_RST   7'h20

`endif

// File: logic/video_irq_regs.v
`timescale 1ns/1ps
`include "video_irq_defines.vh"

module video_irq_regs #(
  parameter [6:0] serial_addr = `SERIAL_ADDR_RST
) (
  input  wire       clock,
  input  wire       rst,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire       caption_data_present,
  input  wire       even_field,
  input  wire       converter_range_fault,
  input  wire       lock_event_latched,
  input  wire       unlock_event_latched,
  input  wire       freerun_change_latched,
  input  wire       copy_protect_event_latched,
  output reg        irq_out,
  output reg        irq_oe
);

  // ===================================================================
  // Serial port states
  localparam [2:0] st_idle   = 3'h0;
  localparam [2:0] st_addr   = 3'h1;
  localparam [2:0] st_ack_a  = 3'h2;
  localparam [2:0] st_sub    = 3'h3;
  localparam [2:0] st_ack_w  = 3'h4;
  localparam [2:0] st_wr     = 3'h5;
  localparam [2:0] st_rd     = 3'h6;
  localparam [2:0] st_rd_ack = 3'h7;

  reg  [2:0] scl_sync;
  reg  [2:0] sda_sync;
  reg  [2:0] state;
  reg  [3:0] bit_count;
  reg  [7:0] shift;
  reg  [7:0] tx;
  reg  [7:0] pointer;
  reg        read_mode;
  reg        rd_load;
  reg        wr_strobe;
  reg  [7:0] wr_addr;
  reg  [7:0] wr_data;
  reg  [7:0] user_submap;
  reg  [7:0] irq_config;
  reg  [7:0] irq_mask_bank1;
  reg  [7:0] irq_mask_bank2;
  reg  [7:0] irq_status_bank2;
  reg        caption_q;
  reg        field_q;
  reg        range_q;
  reg        manual_q;
  reg  [7:0] next_status;
  reg  [7:0] read_data;
  wire [7:0] raw_status_bank2;
  wire [7:0] status_set;
  wire [7:0] status_clear;
  wire       in_irq_map;
  wire       scl_rise;
  wire       scl_fall;
  wire       bus_start;
  wire       bus_stop;
  wire       manual_irq_enable;
  wire [1:0] irq_pin_drive_select;
  wire       irq_active;

  // ===================================================================
  // Pin synchronisers; stage 0 feeds only stage 1
  always @(posedge clock) begin
    if (rst) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
    end
  end

  // Bus events from settled samples
  assign scl_rise  = scl_sync[1] & ~scl_sync[2];
  assign scl_fall  = ~scl_sync[1] & scl_sync[2];
  assign bus_start = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
  assign bus_stop  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

  // ===================================================================
  // Register map decode
  assign in_irq_map = user_submap[`SUBMAP_SEL_LSB +: 2]
                      == `SUBMAP_SEL_IRQ;
  assign manual_irq_enable    = irq_config[`CFG_MANUAL_BIT];
  assign irq_pin_drive_select = irq_config[`CFG_DRIVE_LSB +: 2];

  // Live indications, never touched by clear or mask
  assign raw_status_bank2 = {manual_irq_enable, 1'b0, converter_range_fault,
                             even_field, 3'h0,
                             caption_data_present};

  // Read mux; write-only and unmapped offsets read zero
  always @* begin
    read_data = `RST_BYTE;
    if (pointer == `OFS_USER_SUBMAP) begin
      read_data = user_submap;
    end else if (in_irq_map) begin
      case (pointer)
        `OFS_IRQ_CONFIG:  read_data = irq_config;
        `OFS_IRQ_MASK1:   read_data = irq_mask_bank1;
        `OFS_RAW_STATUS2: read_data = raw_status_bank2;
        `OFS_IRQ_STATUS2: read_data = irq_status_bank2;
        `OFS_IRQ_MASK2:   read_data = irq_mask_bank2;
        default:          read_data = `RST_BYTE;
      endcase
    end
  end

  // ===================================================================
  // Serial slave: address, sub-address, data with auto-increment
  always @(posedge clock) begin
    if (rst) begin
      state     <= st_idle;
      bit_count <= 4'h0;
      shift     <= 8'h00;
      tx        <= 8'h00;
      pointer   <= 8'h00;
      read_mode <= 1'b0;
      rd_load   <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 8'h00;
      sda_out   <= 1'b0;
      sda_oe    <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      sda_out   <= 1'b0;
      if (bus_start) begin
        state     <= st_addr;
        bit_count <= 4'h0;
        sda_oe    <= 1'b0;
      end else if (bus_stop) begin
        state  <= st_idle;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          st_idle: begin
            sda_oe <= 1'b0;
          end
          st_addr, st_sub, st_wr: begin
            if (scl_rise) begin
              shift     <= {shift[6:0], sda_sync[1]};
              bit_count <= bit_count + 4'h1;
            end else if (scl_fall && bit_count == 4'h8) begin
              bit_count <= 4'h0;
              if (state == st_addr) begin
                if (shift[7:1] == serial_addr) begin
                  sda_oe    <= 1'b1;
                  read_mode <= shift[0];
                  state     <= st_ack_a;
                end else begin
                  state <= st_idle;
                end
              end else begin
                if (state == st_sub) begin
                  pointer <= shift;
                end else begin
                  wr_strobe <= 1'b1;
                  wr_addr   <= pointer;
                  wr_data   <= shift;
                  rd_load   <= 1'b1;
                end
                sda_oe <= 1'b1;
                state  <= st_ack_w;
              end
            end
          end
          st_ack_a: begin
            if (scl_fall) begin
              if (read_mode) begin
                tx        <= read_data;
                sda_oe    <= ~read_data[7];
                bit_count <= 4'h1;
                state     <= st_rd;
              end else begin
                sda_oe <= 1'b0;
                state  <= st_sub;
              end
            end
          end
          st_ack_w: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              if (rd_load) begin
                pointer <= pointer + 8'h01;
              end
              rd_load <= 1'b0;
              state   <= st_wr;
            end
          end
          st_rd: begin
            if (scl_fall) begin
              if (bit_count == 4'h8) begin
                sda_oe <= 1'b0;
                state  <= st_rd_ack;
              end else begin
                sda_oe    <= ~tx[6];
                tx        <= {tx[6:0], 1'b0};
                bit_count <= bit_count + 4'h1;
              end
            end
          end
          st_rd_ack: begin
            // Master ack fetches the next byte, nack ends the read
            if (scl_rise) begin
              if (sda_sync[1]) begin
                state <= st_idle;
              end else begin
                pointer   <= pointer + 8'h01;
                read_mode <= 1'b1;
                state     <= st_ack_a;
              end
            end
          end
          default: begin
            state <= st_idle;
          end
        endcase
      end
    end
  end

  // ===================================================================
  // Writable registers; reserved bits are held at zero except in user_submap, which stores the whole byte
  always @(posedge clock) begin
    if (rst) begin
      user_submap    <= `RST_BYTE;
      irq_config     <= `RST_BYTE;
      irq_mask_bank1 <= `RST_BYTE;
      irq_mask_bank2 <= `RST_BYTE;
    end else if (wr_strobe) begin
      if (wr_addr == `OFS_USER_SUBMAP) begin
        user_submap <= wr_data;
      end else if (in_irq_map) begin
        case (wr_addr)
          `OFS_IRQ_CONFIG: irq_config <= wr_data & `CFG_WR_BITS;
          `OFS_IRQ_MASK1:
            irq_mask_bank1 <= wr_data & `MASK1_WR_BITS;
          `OFS_IRQ_MASK2:
            irq_mask_bank2 <= wr_data & `MASK2_WR_BITS;
          default: irq_mask_bank2 <= irq_mask_bank2;
        endcase
      end
    end
  end

  // ===================================================================
  // Event edge detection on same-clock decoder signals
  always @(posedge clock) begin
    if (rst) begin
      caption_q <= 1'b0;
      field_q   <= 1'b0;
      range_q   <= 1'b0;
      manual_q  <= 1'b0;
    end else begin
      caption_q <= caption_data_present;
      field_q   <= even_field;
      range_q   <= converter_range_fault;
      manual_q  <= manual_irq_enable;
    end
  end

  // Caption input comes from the mode 1 slicer only
  assign status_set = {manual_irq_enable & ~manual_q,
                       1'b0,
                       converter_range_fault & ~range_q,
                       even_field ^ field_q,
                       3'h0,
                       caption_data_present & ~caption_q};

  // Write-only clear; a zero bit leaves its latch alone
  assign status_clear = (wr_strobe && in_irq_map &&
                         wr_addr == `OFS_IRQ_CLEAR2) ?
                        (wr_data & `MASK2_WR_BITS) : 8'h00;

  // Set beats a clear in the same cycle so no event is lost
  always @* begin
    next_status = (irq_status_bank2 & ~status_clear) | status_set;
  end

  always @(posedge clock) begin
    if (rst) begin
      irq_status_bank2 <= `RST_BYTE;
    end else begin
      irq_status_bank2 <= next_status;
    end
  end

  // ===================================================================
  // Interrupt pin; held level until the source is cleared or masked
  assign irq_active = |(irq_status_bank2 & irq_mask_bank2) |
                      |({1'b0, copy_protect_event_latched,
                         freerun_change_latched, 3'h0,
                         unlock_event_latched,
                         lock_event_latched} & irq_mask_bank1);

  always @(posedge clock) begin
    if (rst) begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end else begin
      case (irq_pin_drive_select)
        `DRIVE_ACTIVE_LOW: begin
          irq_out <= ~irq_active;
          irq_oe  <= 1'b1;
        end
        `DRIVE_ACTIVE_HIGH: begin
          irq_out <= irq_active;
          irq_oe  <= 1'b1;
        end
        default: begin
          // Reserved code falls back to open drain, the safe choice
          irq_out <= 1'b0;
          irq_oe  <= irq_active;
        end
      endcase
    end
  end

endmodule

// File: testbench/video_irq_regs_asserts.sv
`timescale 1ns/1ps
// =====================================================================
// Port-level checks for the interrupt register block
module video_irq_regs_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic caption_data_present,
  input wire logic even_field,
  input wire logic converter_range_fault,
  input wire logic lock_event_latched,
  input wire logic unlock_event_latched,
  input wire logic freerun_change_latched,
  input wire logic copy_protect_event_latched,
  input wire logic irq_out,
  input wire logic irq_oe
);
  logic       scl_q;
  logic [6:0] ev_q;
  logic [3:0] scl_age;
  logic [3:0] fall_age;
  logic [3:0] ev_age;
  wire  [6:0] ev = {caption_data_present, even_field, converter_range_fault,
    lock_event_latched, unlock_event_latched, freerun_change_latched,
    copy_protect_event_latched};

  function automatic [3:0] inc(input [3:0] a);
    return a + {3'h0, a != 4'hF};
  endfunction

  // Ages saturate so a long idle never wraps back to a busy reading
  always_ff @(posedge clock) begin
    scl_q <= scl_in;
    ev_q <= ev;
    scl_age <= (rst || scl_q != scl_in) ? 4'h0 : inc(scl_age);
    fall_age <= rst ? 4'hF : (scl_q && !scl_in) ? 4'h0 : inc(fall_age);
    ev_age <= (rst || ev_q != ev) ? 4'h0 : inc(ev_age);
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence quiet_after_rst;
    (!sda_oe && !irq_oe && !irq_out) [*3];
  endsequence

  reset_quiet_a: assert property ($fell(rst) |-> quiet_after_rst)
    else $error("outputs busy after reset");
  irq_hold_quiet_a: assert property (
    scl_age >= 4'hA && ev_age >= 4'h5 |-> $stable(irq_out) && $stable(irq_oe))
    else $error("irq pins moved while idle");
  irq_by_write_a: assert property (
    ($changed(irq_oe) || $changed(irq_out)) && ev_age >= 4'h5
      |-> fall_age <= 4'h9)
    else $error("irq pins moved without a write");
  od_no_high_a: assert property (!irq_oe |-> !irq_out)
    else $error("irq value high while undriven");
  sda_low_only_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  drive_on_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive moved with clock high");
  ack_after_fall_a: assert property ($rose(sda_oe) |-> fall_age <= 4'h5)
    else $error("data drive late after clock fall");
  release_after_fall_a: assert property ($fell(sda_oe) |-> fall_age <= 4'h5)
    else $error("data release late after clock fall");
endmodule

// File: testbench/serial_host.sv
`timescale 1ns/1ps
// =====================================================================
// Host processor on the two-wire control port
module serial_host #(
  parameter [6:0] dev_addr = 7'h20
) (
  input  wire clock,
  input  wire sda_line,
  output reg  scl,
  output reg  sda_low
);
  reg   [6:0] target;
  reg   [7:0] junk;
  integer     nacks;

  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    target = dev_addr;
    nacks = 0;
  end

  // Six clocks a phase leave room for the port's input synchronisers
  task tick;
    repeat (6) @(negedge clock);
  endtask

  // Data moves only while the clock is low; sampled in the high phase
  task bit_io(input b, output r);
    begin
      sda_low = !b;
      tick;
      scl = 1'b1;
      tick;
      r = sda_line;
      scl = 1'b0;
      tick;
    end
  endtask

  task byte_io(input [7:0] tx, input wr, output [7:0] rx);
    integer k;
    reg     a;
    begin
      for (k = 7; k >= 0; k = k - 1)
        bit_io(tx[k], rx[k]);
      bit_io(1'b1, a);
      if (wr && a)
        nacks = nacks + 1;
    end
  endtask

  // Also serves as repeated start, entered with the clock low
  task start_cond;
    begin
      sda_low = 1'b0;
      tick;
      scl = 1'b1;
      tick;
      sda_low = 1'b1;
      tick;
      scl = 1'b0;
      tick;
    end
  endtask

  task stop_cond;
    begin
      sda_low = 1'b1;
      tick;
      scl = 1'b1;
      tick;
      sda_low = 1'b0;
      tick;
    end
  endtask

  task write_reg(input [7:0] sub, input [7:0] d);
    begin
      start_cond;
      byte_io({target, 1'b0}, 1'b1, junk);
      byte_io(sub, 1'b1, junk);
      byte_io(d, 1'b1, junk);
      stop_cond;
    end
  endtask

  task read_reg(input [7:0] sub, output [7:0] d);
    begin
      start_cond;
      byte_io({target, 1'b0}, 1'b1, junk);
      byte_io(sub, 1'b1, junk);
      start_cond;
      byte_io({target, 1'b1}, 1'b1, junk);
      byte_io(8'hFF, 1'b0, d);
      stop_cond;
    end
  endtask
endmodule

// File: testbench/video_irq_regs_tb.sv
`timescale 1ns/1ps
// =====================================================================
// Self-checking bench for the interrupt register block
module video_irq_regs_tb;
  reg         clock;
  reg         rst;
  reg         caption;
  reg         field;
  reg         range;
  reg  [3:0]  bank1;
  reg  [31:0] seed;
  reg  [7:0]  val;
  reg  [7:0]  msk;
  integer     mismatches;
  integer     samples_checked;
  integer     i;
  integer     m;
  wire        scl;
  wire        sda_low;
  wire        sda_out;
  wire        sda_oe;
  wire        irq_out;
  wire        irq_oe;
  // Pulled-up data line; either party may pull it low
  wire        sda_line = !(sda_low || (sda_oe && !sda_out));

  initial clock = 1'b0;
  always #50 clock = ~clock;

  serial_host host (.clock(clock), .sda_line(sda_line), .scl(scl),
    .sda_low(sda_low));

  video_irq_regs uut (.clock(clock), .rst(rst), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .caption_data_present(caption), .even_field(field),
    .converter_range_fault(range), .lock_event_latched(bank1[0]),
    .unlock_event_latched(bank1[1]), .freerun_change_latched(bank1[2]),
    .copy_protect_event_latched(bank1[3]), .irq_out(irq_out),
    .irq_oe(irq_oe));

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  // Expected {oe, out} for a drive select code and pending activity
  function [1:0] drive(input [1:0] sel, input act);
    case (sel)
      2'h1: drive = {1'b1, !act};
      2'h2: drive = {1'b1, act};
      default: drive = {act, 1'b0};
    endcase
  endfunction

  task check(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task rd(input [7:0] sub, input [7:0] exp);
    begin
      host.read_reg(sub, val);
      check(val, exp);
    end
  endtask

  // Status and pin each take a clock, so wait a little longer
  task pins(input [1:0] exp);
    begin
      repeat (4) @(negedge clock);
      check({6'h00, irq_oe, irq_out}, {6'h00, exp});
    end
  endtask

  task end_of_test;
    begin
      if (mismatches == 0 && samples_checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Main sequence: live bits, latches, clears, pin modes, bank 1 masks
  initial begin
    rst = 1'b1;
    {caption, field, range} = 3'h0;
    bank1 = 4'h0;
    seed = 32'h0771;
    mismatches = 0;
    samples_checked = 0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    pins(2'h0);
    host.write_reg(8'h0E, 8'h01);
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      {caption, field, range} = seed[2:0];
      rd(8'h45, {2'h0, range, field, 3'h0, caption});
    end
    {caption, field, range} = 3'h0;
    host.write_reg(8'h47, 8'hB1);
    rd(8'h46, 8'h00);
    caption = 1'b1;
    rd(8'h46, 8'h01);
    {field, range} = 2'h3;
    rd(8'h46, 8'h31);
    host.write_reg(8'h46, 8'h00);
    rd(8'h46, 8'h31);
    host.write_reg(8'h47, 8'h00);
    rd(8'h46, 8'h31);
    host.write_reg(8'h47, 8'h01);
    rd(8'h46, 8'h30);
    rd(8'h45, 8'h31);
    host.write_reg(8'h47, 8'h10);
    rd(8'h46, 8'h20);
    host.write_reg(8'h47, 8'h20);
    rd(8'h46, 8'h00);
    host.write_reg(8'h40, 8'h04);
    rd(8'h46, 8'h80);
    rd(8'h45, 8'hB1);
    rd(8'h47, 8'h00);
    pins(2'h0);
    host.write_reg(8'h48, 8'h80);
    for (m = 0; m < 8; m = m + 1) begin
      if (m == 4)
        host.write_reg(8'h47, 8'h80);
      host.write_reg(8'h40, {6'h01, m[1:0]});
      pins(drive(m[1:0], !m[2]));
    end
    host.write_reg(8'h40, 8'h02);
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      msk = seed[7:0];
      bank1 = seed[11:8];
      host.write_reg(8'h44, msk);
      pins(drive(2'h2, |(bank1 & {msk[6:5], msk[1:0]})));
      rd(8'h44, msk & 8'h63);
    end
    check(host.nacks[7:0], 8'h00);
    host.target = 7'h21;
    host.write_reg(8'h44, 8'hFF);
    host.target = 7'h20;
    check(host.nacks[7:0], 8'h03);
    rd(8'h44, msk & 8'h63);
    end_of_test;
  end

  // Hang guard, well beyond the length of the sequence above
  initial begin
    repeat (90000) @(posedge clock);
    mismatches = mismatches + 1;
    end_of_test;
  end
endmodule

bind video_irq_regs video_irq_regs_asserts chk (.clock(clock), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .caption_data_present(caption_data_present), .even_field(even_field),
  .converter_range_fault(converter_range_fault),
  .lock_event_latched(lock_event_latched),
  .unlock_event_latched(unlock_event_latched),
  .freerun_change_latched(freerun_change_latched),
  .copy_protect_event_latched(copy_protect_event_latched),
  .irq_out(irq_out), .irq_oe(irq_oe));
